// ---- dv/srs_chk.sv ----
// Concurrent checks on the reset sequencer ports
`timescale 1ns/100ps
`default_nettype none
module srs_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_reset_n_pin,
    input wire logic power_on_detect,
    input wire srs_pkg::srs_sync_src_t sync_src,
    input wire srs_pkg::srs_resets_t resets,
    input wire logic oscillator_clock_en,
    input wire logic system_clock_en
);
    import srs_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] cnt_r;
    // ----
    // Enable pulses since the last release step
    // ----
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 8'h00;
        else if (resets.combined_rst || $fell(resets.clock_generator_reset)
                 || $fell(resets.peripheral_reset))
            cnt_r <= 8'h00;
        else if (resets.clock_generator_reset ? oscillator_clock_en : system_clock_en)
            cnt_r <= cnt_r + 8'h01;
    end
    sequence s_held3;
        resets.combined_rst [*3];
    endsequence
    sequence s_step32;
        cnt_r >= 8'h1f && cnt_r <= 8'h21;
    endsequence
    property p_tp;
        (!power_on_detect && !resets.test_port_rst) |=> !resets.test_port_rst;
    endproperty
    a_tp: assert property (p_tp) else $error("test port reset without power-on");
    property p_por;
        power_on_detect |-> ##[0:3] (resets.test_port_rst && resets.combined_rst);
    endproperty
    a_por: assert property (p_por) else $error("power-on not applied");
    property p_pin;
        !ext_reset_n_pin |-> ##[0:3] (resets.combined_rst && resets.core_rst);
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset not applied");
    property p_sw;
        (sync_src.system_control_write && !resets.sync_rst) |-> ##[1:3] resets.combined_rst;
    endproperty
    a_sw: assert property (p_sw) else $error("software reset not applied");
    property p_sync;
        $fell(resets.sync_rst) |-> cnt_r >= 8'h02 && cnt_r <= 8'h04;
    endproperty
    a_sync: assert property (p_sync) else $error("sync reset length");
    property p_clkgen;
        $fell(resets.clock_generator_reset) |-> s_step32 ##0 !resets.sync_rst;
    endproperty
    a_clkgen: assert property (p_clkgen) else $error("clock gen stretch");
    property p_perip;
        $fell(resets.peripheral_reset) |-> s_step32;
    endproperty
    a_perip: assert property (p_perip) else $error("peripheral stretch");
    property p_core;
        $fell(resets.core_rst) |-> s_step32 ##0 !resets.peripheral_reset;
    endproperty
    a_core: assert property (p_core) else $error("core stretch");
    property p_sysen;
        s_held3 |-> !system_clock_en;
    endproperty
    a_sysen: assert property (p_sysen) else $error("system clock in reset");
    property p_osc;
        $rose(oscillator_clock_en) |=> !oscillator_clock_en;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator pulse width");
endmodule
bind srs_sequencer srs_chk u_srs_chk (
    .core_clk(core_clk),
    .rst(rst),
    .ext_reset_n_pin(ext_reset_n_pin),
    .power_on_detect(power_on_detect),
    .sync_src(sync_src),
    .resets(resets),
    .oscillator_clock_en(oscillator_clock_en),
    .system_clock_en(system_clock_en)
);
`default_nettype wire

// ---- dv/srs_far_model.sv ----
// Model of clock generator, peripherals and core
`timescale 1ns/100ps
`default_nettype none
module srs_far_model (
    input wire logic core_clk,
    input wire srs_pkg::srs_resets_t resets,
    input wire logic system_clock_en,
    output var int perip_ticks,
    output var int core_ticks,
    output logic core_running
);
    import srs_pkg::*;
    // ----
    // Clocked but held in reset
    // ----
    always_ff @(posedge core_clk)
    begin
        if (resets.clock_generator_reset)
            perip_ticks <= 0;
        else if (system_clock_en && resets.peripheral_reset)
            perip_ticks <= perip_ticks + 1;
    end
    always_ff @(posedge core_clk)
    begin
        if (resets.peripheral_reset)
            core_ticks <= 0;
        else if (system_clock_en && resets.core_rst)
            core_ticks <= core_ticks + 1;
    end
    assign core_running = !resets.core_rst;
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench of the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    import srs_pkg::*;
    logic core_clk;
    logic rst;
    logic ext_reset_n_pin;
    logic power_on_detect;
    srs_sync_src_t sync_src;
    srs_resets_t resets;
    logic oscillator_clock_en;
    logic system_clock_en;
    int perip_ticks;
    int core_ticks;
    logic core_running;
    int err_count;
    int samples_checked;
    srs_sequencer #(.OSC_DIV(2), .SYS_DIV(2)) u_srs_sequencer (
        .core_clk(core_clk),
        .rst(rst),
        .ext_reset_n_pin(ext_reset_n_pin),
        .power_on_detect(power_on_detect),
        .sync_src(sync_src),
        .resets(resets),
        .oscillator_clock_en(oscillator_clock_en),
        .system_clock_en(system_clock_en)
    );
    srs_far_model u_srs_far_model (
        .core_clk(core_clk),
        .resets(resets),
        .system_clock_en(system_clock_en),
        .perip_ticks(perip_ticks),
        .core_ticks(core_ticks),
        .core_running(core_running)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ----
    // Shared tasks
    // ----
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bit 0 core, 1 peripheral, 2 clock gen, 3 sync, 4 combined
    task automatic wait_bit(input int idx, input int bound, output int n);
        n = 0;
        while (resets[idx] !== 1'b0)
        begin
            cyc(1);
            n++;
            if (n > bound)
            begin
                err_count++;
                $display("wrong value release %0d expected 0 seen %b", idx, resets[idx]);
                stop_test();
            end
        end
    endtask
    task automatic run_seq;
        int n;
        wait_bit(2, 200, n);
        wait_bit(1, 200, n);
        check("periph ticks", 8'h01, perip_ticks >= 31 && perip_ticks <= 33);
        wait_bit(0, 200, n);
        check("core ticks", 8'h01, core_ticks >= 31 && core_ticks <= 33);
        check("core runs", 8'h01, core_running);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_por;
        int n;
        cyc(4);
        check("por test port", 8'h01, resets.test_port_rst);
        power_on_detect = 1'b0;
        wait_bit(4, 400, n);
        check("por stretch", 8'h01, n >= 128 && n <= 142);
        check("test port free", 8'h00, resets.test_port_rst);
        wait_bit(2, 200, n);
        check("clock gen stretch", 8'h01, n >= 62 && n <= 68);
        run_seq();
    endtask
    task automatic t_pin;
        int n;
        ext_reset_n_pin = 1'b0;
        cyc(5);
        check("pin combined", 8'h01, resets.combined_rst);
        check("pin core", 8'h01, resets.core_rst);
        check("pin test port", 8'h00, resets.test_port_rst);
        ext_reset_n_pin = 1'b1;
        wait_bit(4, 20, n);
        wait_bit(3, 20, n);
        check("sync hold", 8'h01, n >= 4 && n <= 8);
        run_seq();
    endtask
    task automatic t_sync(input int which);
        int n;
        sync_src = srs_sync_src_t'(3'b100 >> which);
        cyc(1);
        sync_src = 3'b000;
        cyc(4);
        check("source combined", 8'h01, resets.combined_rst);
        wait_bit(4, 40, n);
        // A source during the sync hold is ignored
        sync_src = srs_sync_src_t'(3'b100 >> which);
        cyc(1);
        sync_src = 3'b000;
        repeat (10)
        begin
            cyc(1);
            check("refused source", 8'h00, resets.combined_rst);
        end
        check("source test port", 8'h00, resets.test_port_rst);
        run_seq();
    endtask
    initial
    begin
        rst = 1'b1;
        ext_reset_n_pin = 1'b1;
        power_on_detect = 1'b1;
        sync_src = 3'b000;
        err_count = 0;
        samples_checked = 0;
        cyc(16);
        rst = 1'b0;
        t_por();
        t_pin();
        for (int i = 0; i < 3; i++)
            t_sync(i);
        stop_test();
    end
endmodule
`default_nettype wire

// ---- logic/srs_pkg.sv ----
// Shared constants and types of the system reset sequencer
package srs_pkg;
    localparam int POR_EXT_CYCLES = 64;
    localparam int COMB_EXT_CYCLES = 32;
    localparam int SYNC_RST_CYCLES = 3;
    localparam int PERIPH_EXT_CYCLES = 32;
    localparam int CORE_EXT_CYCLES = 32;
    localparam int MAX_OSC_STRETCH = 96;
    localparam int OSC_DIV_DEFAULT = 32;
    localparam int SYS_DIV_DEFAULT = 8;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] CNT_POR = CNT_W'(POR_EXT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_COMB = CNT_W'(COMB_EXT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_SYNC = CNT_W'(SYNC_RST_CYCLES);
    localparam logic [CNT_W-1:0] CNT_PERIPH = CNT_W'(PERIPH_EXT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_CORE = CNT_W'(CORE_EXT_CYCLES);

    typedef struct packed {
        logic test_port_rst;
        logic combined_rst;
        logic sync_rst;
        logic clock_generator_reset;
        logic peripheral_reset;
        logic core_rst;
    } srs_resets_t;

    typedef struct packed {
        logic system_control_write;
        logic watchdog_timeout_reset;
        logic watchdog_lost_reference_reset;
    } srs_sync_src_t;

    typedef enum logic [2:0] {
        ST_CLKGEN_HOLD,
        ST_PERIPH_HOLD,
        ST_CORE_HOLD,
        ST_RUN
    } srs_phase_t;
endpackage

// ---- logic/srs_sequencer.sv ----
// Phased system reset sequencer with enable-based oscillator and system clocks
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Five reset sources: pin and power-on asynchronous, software and two watchdog synchronous.
// - A system control register write raises the software reset inside this block.
// - Test-port reset follows only the power-on reset.
// - Stretched power-on reset releases 64 oscillator cycles after the detector deasserts.
// - Combined reset ORs stretched power-on, pin, watchdog and software resets.
// - Control, sync reset generator and clock stretcher run only after combined release.
// - Sync reset for software and watchdog logic releases 3 oscillator cycles after combined.
// - Clock generator reset releases 32 oscillator cycles after combined reset deasserts.
// - Clock generator reset releases on an oscillator falling edge.
// - Clock generator release starts system clock and peripheral stretcher.
// - Peripheral reset releases 32 system cycles after clock generator reset.
// - Peripheral release starts the core reset stretcher.
// - Core reset releases 32 system cycles after peripheral reset.
// - Peripheral and core resets release on a delayed system clock falling edge.
// - Core release lets the processor run, ending the start-up sequence.
// - Power-on and combined stretch counters count oscillator cycles.
// - Stretch before clock generator release totals at most 96 oscillator cycles.
// - The block raises no interrupts.
module srs_sequencer #(
    parameter int OSC_DIV = srs_pkg::OSC_DIV_DEFAULT,
    parameter int SYS_DIV = srs_pkg::SYS_DIV_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_reset_n_pin,
    input wire logic power_on_detect,
    input wire srs_pkg::srs_sync_src_t sync_src,
    output srs_pkg::srs_resets_t resets,
    output logic oscillator_clock_en,
    output logic system_clock_en
);
    import srs_pkg::*;

    if (OSC_DIV < 2 || OSC_DIV % 2 != 0 || OSC_DIV > 65536
        || SYS_DIV < 2 || SYS_DIV % 2 != 0 || SYS_DIV > 65536)
    begin : g_div_check
        $error("Clock dividers must be even, from 2 to 65536");
    end
    if (POR_EXT_CYCLES + COMB_EXT_CYCLES > MAX_OSC_STRETCH)
    begin : g_stretch_check
        $error("Oscillator stretch exceeds its limit");
    end

    // ----------------------------------------
    // Clock enable dividers
    // ----------------------------------------
    logic [15:0] osc_div_r;
    logic [15:0] sys_div_r;
    logic osc_rise_r;
    logic osc_fall_r;
    logic sys_rise_r;
    logic sys_fall_r;
    logic clock_generator_reset_r;
    logic periph_rst_r;
    logic core_rst_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            osc_div_r <= 16'h0000;
            osc_rise_r <= 1'b0;
            osc_fall_r <= 1'b0;
        end
        else
        begin
            osc_div_r <= (osc_div_r == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_div_r + 16'h0001;
            osc_rise_r <= (osc_div_r == 16'(OSC_DIV - 1));
            osc_fall_r <= (osc_div_r == 16'(OSC_DIV / 2 - 1));
        end
    end

    // System clock only runs once the clock generator leaves reset
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sys_div_r <= 16'h0000;
            sys_rise_r <= 1'b0;
            sys_fall_r <= 1'b0;
        end
        else if (clock_generator_reset_r)
        begin
            sys_div_r <= 16'h0000;
            sys_rise_r <= 1'b0;
            sys_fall_r <= 1'b0;
        end
        else
        begin
            sys_div_r <= (sys_div_r == 16'(SYS_DIV - 1)) ? 16'h0000 : sys_div_r + 16'h0001;
            sys_rise_r <= (sys_div_r == 16'(SYS_DIV - 1));
            sys_fall_r <= (sys_div_r == 16'(SYS_DIV / 2 - 1));
        end
    end

    // ----------------------------------------
    // Asynchronous source synchronisers
    // ----------------------------------------
    logic por_meta_r;
    logic por_sync_r;
    logic pin_meta_r;
    logic pin_sync_r;

    always_ff @(posedge core_clk or posedge rst or posedge power_on_detect)
    begin
        if (rst || power_on_detect)
        begin
            por_meta_r <= 1'b1;
            por_sync_r <= 1'b1;
        end
        else if (osc_rise_r)
        begin
            por_meta_r <= 1'b0;
            por_sync_r <= por_meta_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst or negedge ext_reset_n_pin)
    begin
        if (rst || !ext_reset_n_pin)
        begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end
        else if (osc_rise_r)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------
    // Power-on stretcher
    // ----------------------------------------
    logic [CNT_W-1:0] por_cnt_r;
    logic ext_por_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            por_cnt_r <= CNT_ZERO;
            ext_por_r <= 1'b1;
        end
        else if (por_sync_r)
        begin
            por_cnt_r <= CNT_ZERO;
            ext_por_r <= 1'b1;
        end
        else if (osc_rise_r && ext_por_r)
        begin
            por_cnt_r <= por_cnt_r + CNT_ONE;
            ext_por_r <= (por_cnt_r != CNT_POR - CNT_ONE);
        end
    end

    // ----------------------------------------
    // Synchronous sources and combined reset
    // ----------------------------------------
    logic sw_req_r;
    logic wdt_req_r;
    logic comb_r;
    logic sync_rst_r;
    logic [CNT_W-1:0] sync_cnt_r;

    // Requests are held until the sync reset generator clears them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sw_req_r <= 1'b0;
            wdt_req_r <= 1'b0;
        end
        else if (sync_rst_r)
        begin
            sw_req_r <= 1'b0;
            wdt_req_r <= 1'b0;
        end
        else
        begin
            sw_req_r <= sw_req_r | sync_src.system_control_write;
            wdt_req_r <= wdt_req_r | sync_src.watchdog_timeout_reset
                         | sync_src.watchdog_lost_reference_reset;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            comb_r <= 1'b1;
        end
        else
        begin
            comb_r <= ext_por_r | pin_sync_r | sw_req_r | wdt_req_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_cnt_r <= CNT_ZERO;
            sync_rst_r <= 1'b1;
        end
        else if (comb_r)
        begin
            sync_cnt_r <= CNT_ZERO;
            sync_rst_r <= 1'b1;
        end
        else if (osc_rise_r && sync_rst_r)
        begin
            sync_cnt_r <= sync_cnt_r + CNT_ONE;
            sync_rst_r <= (sync_cnt_r != CNT_SYNC - CNT_ONE);
        end
    end

    // ----------------------------------------
    // Clock generator reset stretcher
    // ----------------------------------------
    logic [CNT_W-1:0] clk_cnt_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_cnt_r <= CNT_ZERO;
            clock_generator_reset_r <= 1'b1;
        end
        else if (comb_r)
        begin
            clk_cnt_r <= CNT_ZERO;
            clock_generator_reset_r <= 1'b1;
        end
        else if (osc_rise_r && clk_cnt_r != CNT_COMB)
        begin
            clk_cnt_r <= clk_cnt_r + CNT_ONE;
        end
        else if (osc_fall_r && clk_cnt_r == CNT_COMB)
        begin
            clock_generator_reset_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Peripheral and core phases
    // ----------------------------------------
    srs_phase_t phase_r;
    srs_phase_t phase_nxt;
    logic [CNT_W-1:0] sys_cnt_r;
    logic cnt_done;

    assign cnt_done = (phase_r == ST_PERIPH_HOLD) ? (sys_cnt_r == CNT_PERIPH)
                                                  : (sys_cnt_r == CNT_CORE);

    always_comb
    begin
        phase_nxt = phase_r;
        case (phase_r)
            ST_CLKGEN_HOLD:
            begin
                phase_nxt = ST_PERIPH_HOLD;
            end
            ST_PERIPH_HOLD:
            begin
                if (sys_fall_r && cnt_done)
                begin
                    phase_nxt = ST_CORE_HOLD;
                end
            end
            ST_CORE_HOLD:
            begin
                if (sys_fall_r && cnt_done)
                begin
                    phase_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
                phase_nxt = ST_RUN;
            end
            default:
            begin
                phase_nxt = ST_CLKGEN_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_r <= ST_CLKGEN_HOLD;
        end
        else if (clock_generator_reset_r)
        begin
            phase_r <= ST_CLKGEN_HOLD;
        end
        else
        begin
            phase_r <= phase_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sys_cnt_r <= CNT_ZERO;
        end
        else if (clock_generator_reset_r || phase_r != phase_nxt)
        begin
            sys_cnt_r <= CNT_ZERO;
        end
        else if (sys_rise_r && !cnt_done && phase_r != ST_RUN)
        begin
            sys_cnt_r <= sys_cnt_r + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            periph_rst_r <= 1'b1;
            core_rst_r <= 1'b1;
        end
        else
        begin
            periph_rst_r <= (phase_nxt == ST_CLKGEN_HOLD) || (phase_nxt == ST_PERIPH_HOLD)
                            || clock_generator_reset_r || comb_r;
            core_rst_r <= (phase_nxt != ST_RUN) || clock_generator_reset_r || comb_r;
        end
    end

    // ----------------------------------------
    // Outputs, no interrupt output exists
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            resets <= '1;
            oscillator_clock_en <= 1'b0;
            system_clock_en <= 1'b0;
        end
        else
        begin
            resets.test_port_rst <= por_sync_r;
            resets.combined_rst <= comb_r;
            resets.sync_rst <= sync_rst_r;
            resets.clock_generator_reset <= clock_generator_reset_r;
            resets.peripheral_reset <= periph_rst_r;
            resets.core_rst <= core_rst_r;
            oscillator_clock_en <= osc_rise_r;
            system_clock_en <= sys_rise_r;
        end
    end
endmodule

`default_nettype wire
